/* dv/sgcc_ctrl_assertions.sv */
// Purpose: port-level checks for the scatter/gather command control
// Assumes: single clock domain, rstn asynchronous active low
// Notes: clears are excluded from antecedents because they win over writes
`timescale 1ns/1ps
module sgcc_checker
    import sgcc_pkg::*;
(
    // clock, reset and clears
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       master_clear,
    input wire logic       pci_side_reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    // engine and effects
    input wire logic       dreq_pending,
    input wire logic       fetch_done,
    input wire logic       cur_expire,
    input wire logic       arb_req,
    input wire logic       serve_dreq,
    input wire logic       serve_fetch,
    input wire logic       halt,
    input wire logic       chan_mask_set,
    input wire logic       process_done_strobe,
    input wire logic       cpu_alert_interrupt
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // command write; the pin reset clears two edges late, excluded through $past
    logic cmd_wr;
    assign cmd_wr = reg_wr && reg_addr == SGCC_ADDR_CMD && !master_clear;

    property p_start_fetch;
        cmd_wr && reg_wdata[1:0] == 2'b01 && !$past(pci_side_reset, 2) |=> arb_req;
    endproperty
    a_start_fetch: assert property (p_start_fetch)
        else $error("start did not raise the prefetch request");
    property p_fetch_hold;
        arb_req && !dreq_pending && !fetch_done && !reg_wr && !master_clear
            && !$past(pci_side_reset, 2)
            |=> arb_req;
    endproperty
    a_fetch_hold: assert property (p_fetch_hold)
        else $error("prefetch request dropped before fetch finished");
    property p_stop; cmd_wr && reg_wdata[1:0] == 2'b10 |=> halt && chan_mask_set; endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not halt and mask");
    property p_halt_cause;
        halt |-> $past(reg_wr) && $past(reg_addr) == SGCC_ADDR_CMD
            && $past(reg_wdata[1:0]) == 2'b10;
    endproperty
    a_halt_cause: assert property (p_halt_cause)
        else $error("halt without a stop command");
    property p_idle_cmd; cmd_wr && reg_wdata[0] == reg_wdata[1] |=> !halt && !chan_mask_set;
    endproperty
    a_idle_cmd: assert property (p_idle_cmd)
        else $error("idle or reserved command disturbed the channel");
    property p_prio; dreq_pending |-> serve_dreq && !serve_fetch; endproperty
    a_prio: assert property (p_prio)
        else $error("prefetch served ahead of a transfer request");
    property p_arb; serve_fetch |-> arb_req && !dreq_pending; endproperty
    a_arb: assert property (p_arb)
        else $error("prefetch served without arbitration request");
    property p_one_end; !(process_done_strobe && cpu_alert_interrupt); endproperty
    a_one_end: assert property (p_one_end)
        else $error("both termination indicators at once");
    property p_end_cause;
        process_done_strobe || cpu_alert_interrupt
            |-> $past(cur_expire) ##1 !(process_done_strobe || cpu_alert_interrupt);
    endproperty
    a_end_cause: assert property (p_end_cause)
        else $error("termination pulse without buffer expiry or too long");
endmodule
bind sgcc_ctrl sgcc_checker chk_u (.ref_clk(ref_clk), .rstn(rstn), .master_clear(master_clear),
    .pci_side_reset(pci_side_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .dreq_pending(dreq_pending), .fetch_done(fetch_done),
    .cur_expire(cur_expire), .arb_req(arb_req), .serve_dreq(serve_dreq),
    .serve_fetch(serve_fetch), .halt(halt), .chan_mask_set(chan_mask_set),
    .process_done_strobe(process_done_strobe), .cpu_alert_interrupt(cpu_alert_interrupt));

/* dv/testbench.sv */
// Purpose: directed bench for the scatter/gather command control
// Assumes: register port with read data one cycle after the strobe
// Notes: engine events are one-cycle pulses driven after a rising edge
`timescale 1ns/1ps
module testbench
    import sgcc_pkg::*;
;
    logic       ref_clk, rstn, reg_wr, reg_rd, pci_side_reset, master_clear;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       dreq_pending, fetch_done, fetch_null, base_load, base_to_cur;
    logic       cur_expire, suspended, arb_req, serve_dreq, serve_fetch;
    logic       chan_mask_set, halt, process_done_strobe, cpu_alert_interrupt, irq;
    int         num_errors, n_checks;

    sgcc_ctrl dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pci_side_reset(pci_side_reset), .master_clear(master_clear),
        .dreq_pending(dreq_pending), .fetch_done(fetch_done), .fetch_null(fetch_null),
        .base_load(base_load), .base_to_cur(base_to_cur), .cur_expire(cur_expire),
        .suspended(suspended), .arb_req(arb_req), .serve_dreq(serve_dreq),
        .serve_fetch(serve_fetch), .chan_mask_set(chan_mask_set), .halt(halt),
        .process_done_strobe(process_done_strobe),
        .cpu_alert_interrupt(cpu_alert_interrupt), .irq(irq));

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic finish_test;
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write, strobe dropped after the taking edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the taking edge
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    // pulses {base_load, base_to_cur, fetch_done, cur_expire, master_clear} for one cycle
    task automatic pulse(input logic [4:0] v);
        @(posedge ref_clk);
        {base_load, base_to_cur, fetch_done, cur_expire, master_clear} <= v;
        @(posedge ref_clk);
        {base_load, base_to_cur, fetch_done, cur_expire, master_clear} <= 5'h00;
        #1;
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        finish_test;
    end

    initial begin
        {reg_wr, reg_rd, pci_side_reset, master_clear, dreq_pending, fetch_done} = 6'h0;
        {fetch_null, base_load, base_to_cur, cur_expire, suspended} = 5'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        rstn = 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(SGCC_ADDR_STATUS, 8'h00);
        rd(SGCC_ADDR_CTRL, 8'h01);
        wr(SGCC_ADDR_CMD, 8'h00);
        rd(SGCC_ADDR_STATUS, 8'h00);
        wr(SGCC_ADDR_CMD, 8'h40);
        rd(SGCC_ADDR_STATUS, 8'h20);
        wr(SGCC_ADDR_CMD, 8'h01);
        chk({5'h0, arb_req, serve_fetch, serve_dreq}, 8'h06);
        @(posedge ref_clk);
        dreq_pending <= 1'b1;
        #1 chk({5'h0, arb_req, serve_fetch, serve_dreq}, 8'h05);
        rd(SGCC_ADDR_STATUS, 8'h21);
        dreq_pending <= 1'b0;
        pulse(5'h04);
        chk({7'h0, arb_req}, 8'h00);
        suspended <= 1'b1;
        pulse(5'h02);
        chk({6'h0, process_done_strobe, cpu_alert_interrupt}, 8'h01);
        suspended <= 1'b0;
        rd(SGCC_ADDR_STATUS, 8'h22);
        // sticky events, mask and write-one-to-clear
        rd(SGCC_ADDR_IRQ_ST, 8'h05);
        chk({7'h0, irq}, 8'h00);
        wr(SGCC_ADDR_IRQ_MSK, 8'h04);
        chk({7'h0, irq}, 8'h01);
        wr(SGCC_ADDR_IRQ_ST, 8'h04);
        chk({7'h0, irq}, 8'h00);
        rd(SGCC_ADDR_IRQ_ST, 8'h01);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        rd(SGCC_ADDR_IRQ_MSK, 8'h04);
        // select done strobe and start in one write, list ends at first fetch
        wr(SGCC_ADDR_CMD, 8'hc1);
        fetch_null <= 1'b1;
        pulse(5'h04);
        fetch_null <= 1'b0;
        rd(SGCC_ADDR_STATUS, 8'h81);
        pulse(5'h02);
        chk({6'h0, process_done_strobe, cpu_alert_interrupt}, 8'h02);
        // base and current move, full base blocks the end, restart empties both
        wr(SGCC_ADDR_CMD, 8'h01);
        pulse(5'h10);
        rd(SGCC_ADDR_STATUS, 8'h09);
        pulse(5'h08);
        rd(SGCC_ADDR_STATUS, 8'h05);
        pulse(5'h10);
        suspended <= 1'b1;
        pulse(5'h02);
        chk({6'h0, process_done_strobe, cpu_alert_interrupt}, 8'h00);
        suspended <= 1'b0;
        rd(SGCC_ADDR_STATUS, 8'h09);
        pulse(5'h08);
        // reserved code leaves a running channel alone, then stop
        wr(SGCC_ADDR_CMD, 8'h01);
        rd(SGCC_ADDR_STATUS, 8'h01);
        wr(SGCC_ADDR_CMD, 8'h03);
        chk({6'h0, halt, chan_mask_set}, 8'h00);
        rd(SGCC_ADDR_STATUS, 8'h01);
        wr(SGCC_ADDR_CMD, 8'h02);
        chk({6'h0, halt, chan_mask_set}, 8'h03);
        rd(SGCC_ADDR_STATUS, 8'h02);
        // both clears restore the done strobe selection
        wr(SGCC_ADDR_CMD, 8'h40);
        pulse(5'h01);
        rd(SGCC_ADDR_CTRL, 8'h01);
        wr(SGCC_ADDR_CMD, 8'h40);
        pci_side_reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pci_side_reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(SGCC_ADDR_STATUS, 8'h00);
        finish_test;
    end
endmodule

/* hdl/sgcc_ctrl.sv */
// Purpose: per-channel scatter/gather command and termination control
// Assumes: descriptor fetch and transfer engine live outside this block
// Notes: master clear and reset both restore the termination selection
//
// Operation
// R1 - With selection programmed, last-buffer completion pulses the done strobe if 1, else alerts.
// R2 - Last buffer is the final list buffer or the last one loaded while suspended.
// R3 - Reset or master clear hold the stored selection at 1, choosing the done strobe.
// R4 - A command write with enable 0 keeps the selection; with enable 1 it loads bit 7.
// R5 - Software writes zeros to command bits 5 to 2.
// R6 - Command 00 does nothing but still applies the selection bits.
// R7 - Command 01 starts and at once requests a fetch of the first descriptor.
// R8 - The prefetch request is arbitrated at the channel's own request priority.
// R9 - Inside the channel a pending transfer request beats a pending prefetch.
// R10 - Start sets active, base empty, current empty, not terminated, next-null 0.
// R11 - Start leaves the termination selection as last programmed.
// R12 - Command 10 halts at once and sets terminate and the channel mask.
// R13 - Command 11 is treated as no operation.
// R14 - Status bit 5 reads 0 for the done strobe and 1 for the alert line.
`timescale 1ns/1ps
module sgcc_ctrl
    import sgcc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // reset coming from the pci side, asynchronous pin
    input  wire logic       pci_side_reset,
    // master clear from the dma register decoder, same clock
    input  wire logic       master_clear,
    // channel transfer engine, same clock
    input  wire logic       dreq_pending,
    input  wire logic       fetch_done,
    input  wire logic       fetch_null,
    input  wire logic       base_load,
    input  wire logic       base_to_cur,
    input  wire logic       cur_expire,
    input  wire logic       suspended,
    // arbitration towards other channels
    output logic            arb_req,
    output logic            serve_dreq,
    output logic            serve_fetch,
    // channel effects
    output logic            chan_mask_set,
    output logic            halt,
    output logic            process_done_strobe,
    output logic            cpu_alert_interrupt,
    output logic            irq
);
    // synchronised pin reset and decoded command
    logic                 pci_rst_s;
    logic                 clr;
    logic                 cmd_wr;
    sgcc_cmd_t            cmd;
    logic                 last_buf;
    logic                 done_ev;

    // scatter/gather flags
    logic                 sel_ff;
    logic                 nxt_sel;
    logic                 act_ff;
    logic                 nxt_act;
    logic                 base_ff;
    logic                 nxt_base;
    logic                 cur_ff;
    logic                 nxt_cur;
    logic                 term_ff;
    logic                 nxt_term;
    logic                 null_ff;
    logic                 nxt_null;
    logic                 fetch_ff;
    logic                 nxt_fetch;
    // one-cycle effect pulses
    logic                 fin_ff;
    logic                 nxt_fin;
    logic                 alert_ff;
    logic                 nxt_alert;
    logic                 mask_ff;
    logic                 nxt_mask;
    logic                 halt_ff;
    logic                 nxt_halt;
    // interrupt registers
    logic [SGCC_EV_W-1:0] ist_ff;
    logic [SGCC_EV_W-1:0] nxt_ist;
    logic [SGCC_EV_W-1:0] imsk_ff;
    logic [SGCC_EV_W-1:0] nxt_imsk;
    logic [SGCC_EV_W-1:0] ev;
    // read path
    logic [7:0]           rd_ff;
    logic [7:0]           nxt_rd;
    logic [7:0]           status;

    // pin reset crosses into ref_clk before use
    sgcc_sync #(
        .W (1)
    ) u_rst_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .d       (pci_side_reset),
        .q       (pci_rst_s)
    );

    // decode
    assign clr    = pci_rst_s | master_clear;
    assign cmd_wr = reg_wr && (reg_addr == SGCC_ADDR_CMD);
    assign cmd    = sgcc_cmd_t'(reg_wdata[SGCC_CMD_MSB:SGCC_CMD_LSB]);
    // bits 5:2 are ignored; software keeps them zero
    // R5
    // final list buffer, or last loaded while suspended, expiring
    assign last_buf = cur_expire && !base_ff && (null_ff || suspended); // R2
    assign done_ev  = act_ff && last_buf;

    // scatter/gather state
    always_comb begin
        nxt_sel   = sel_ff;
        nxt_act   = act_ff;
        nxt_base  = base_ff;
        nxt_cur   = cur_ff;
        nxt_term  = term_ff;
        nxt_null  = null_ff;
        nxt_fetch = fetch_ff;
        nxt_fin   = 1'b0;
        nxt_alert = 1'b0;
        nxt_mask  = 1'b0;
        nxt_halt  = 1'b0;
        // engine progress
        if (fetch_done) begin
            nxt_fetch = 1'b0;
            nxt_null  = fetch_null;
        end
        if (base_load) begin
            nxt_base = 1'b1;
        end
        // a move checked after a load, so a move wins in one cycle
        if (base_to_cur) begin
            nxt_base = 1'b0;
            nxt_cur  = 1'b1;
        end
        if (cur_expire) begin
            nxt_cur = 1'b0;
        end
        // done only counts while active, so an expiry after stop is silent
        if (done_ev) begin
            nxt_act   = 1'b0;
            nxt_term  = 1'b1;
            nxt_fin   = sel_ff;  // R1
            nxt_alert = !sel_ff; // R1
        end
        // software command wins over engine events of the same cycle, except that a stop still lets a done pulse through
        if (cmd_wr) begin
            if (reg_wdata[SGCC_CMD_EN_BIT]) begin
                nxt_sel = reg_wdata[SGCC_CMD_SEL_BIT]; // R4 R6
            end
            case (cmd)
                SGCC_CMD_START: begin
                    nxt_act   = 1'b1; // R10
                    nxt_base  = 1'b0; // R10
                    nxt_cur   = 1'b0; // R10
                    nxt_term  = 1'b0; // R10
                    nxt_null  = 1'b0; // R10
                    nxt_fetch = 1'b1; // R7
                    nxt_fin   = 1'b0;
                    nxt_alert = 1'b0;
                    // selection untouched here R11
                end
                SGCC_CMD_STOP: begin
                    nxt_act   = 1'b0;
                    nxt_fetch = 1'b0;
                    nxt_term  = 1'b1; // R12
                    nxt_mask  = 1'b1; // R12
                    nxt_halt  = 1'b1; // R12
                end
                SGCC_CMD_NOP: begin
                end
                default: begin
                    // reserved code leaves state alone R13
                end
            endcase
        end
        // clear comes last so it beats a command written in the same cycle, except the stop's halt and mask pulses
        if (clr) begin
            nxt_sel   = SGCC_SEL_RST; // R3
            nxt_act   = 1'b0;
            nxt_base  = 1'b0;
            nxt_cur   = 1'b0;
            nxt_term  = 1'b0;
            nxt_null  = 1'b0;
            nxt_fetch = 1'b0;
            nxt_fin   = 1'b0;
            nxt_alert = 1'b0;
        end
    end

    // flags and pulses register together
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sel_ff   <= SGCC_SEL_RST; // R3
            act_ff   <= 1'b0;
            base_ff  <= 1'b0;
            cur_ff   <= 1'b0;
            term_ff  <= 1'b0;
            null_ff  <= 1'b0;
            fetch_ff <= 1'b0;
            fin_ff   <= 1'b0;
            alert_ff <= 1'b0;
            mask_ff  <= 1'b0;
            halt_ff  <= 1'b0;
        end else begin
            sel_ff   <= nxt_sel;
            act_ff   <= nxt_act;
            base_ff  <= nxt_base;
            cur_ff   <= nxt_cur;
            term_ff  <= nxt_term;
            null_ff  <= nxt_null;
            fetch_ff <= nxt_fetch;
            fin_ff   <= nxt_fin;
            alert_ff <= nxt_alert;
            mask_ff  <= nxt_mask;
            halt_ff  <= nxt_halt;
        end
    end

    // arbitration: prefetch shares the channel's request slot
    // outside arbiter sees one request per channel; dreq goes first inside
    assign arb_req     = dreq_pending | fetch_ff;      // R8
    assign serve_dreq  = dreq_pending;                 // R9
    assign serve_fetch = fetch_ff & ~dreq_pending;     // R9

    // status byte, bit 5 is 1 for the alert line
    always_comb begin
        // reserved bits 6 and 4 stay zero
        status = SGCC_BYTE_RST;
        status[SGCC_ST_NULL_BIT] = null_ff;
        status[SGCC_ST_SEL_BIT]  = ~sel_ff; // R14
        status[SGCC_ST_BASE_BIT] = base_ff;
        status[SGCC_ST_CUR_BIT]  = cur_ff;
        status[SGCC_ST_TERM_BIT] = term_ff;
        status[SGCC_ST_ACT_BIT]  = act_ff;
    end

    // interrupt events; set beats write-one-to-clear
    always_comb begin
        ev = '0;
        ev[SGCC_EV_START] = cmd_wr && (cmd == SGCC_CMD_START);
        ev[SGCC_EV_STOP]  = cmd_wr && (cmd == SGCC_CMD_STOP);
        ev[SGCC_EV_DONE]  = done_ev;
        nxt_ist  = ist_ff;
        nxt_imsk = imsk_ff;
        if (reg_wr && reg_addr == SGCC_ADDR_IRQ_ST) begin
            nxt_ist = ist_ff & ~reg_wdata[SGCC_EV_W-1:0];
        end
        if (reg_wr && reg_addr == SGCC_ADDR_IRQ_MSK) begin
            nxt_imsk = reg_wdata[SGCC_EV_W-1:0];
        end
        // set after clear, so an event in the clearing cycle is not lost
        nxt_ist = nxt_ist | ev;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ist_ff  <= '0;
            imsk_ff <= '0;
        end else begin
            ist_ff  <= nxt_ist;
            imsk_ff <= nxt_imsk;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    // reads have no side effects, so a stray read strobe is harmless
    always_comb begin
        nxt_rd = SGCC_BYTE_RST;
        if (reg_rd) begin
            case (reg_addr)
                SGCC_ADDR_STATUS:  nxt_rd = status;
                SGCC_ADDR_IRQ_ST:  nxt_rd = {5'h00, ist_ff};
                SGCC_ADDR_IRQ_MSK: nxt_rd = {5'h00, imsk_ff};
                SGCC_ADDR_CTRL:    nxt_rd = {6'h00, fetch_ff, sel_ff};
                default:           nxt_rd = SGCC_BYTE_RST; // command is write only
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_ff <= SGCC_BYTE_RST;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    // outputs
    assign reg_rdata           = rd_ff;
    assign chan_mask_set       = mask_ff;
    assign halt                = halt_ff;
    assign process_done_strobe = fin_ff;
    assign cpu_alert_interrupt = alert_ff;
    assign irq                 = |(ist_ff & imsk_ff);
endmodule

/* hdl/sgcc_pkg.sv */
// Purpose: constants for the scatter/gather command control block
// Assumes: registers reached over a plain address/strobe port, byte data
// Notes: offsets below are register indices on the local port
package sgcc_pkg;
    // register map (local port addresses)
    localparam logic [3:0] SGCC_ADDR_CMD     = 4'h0;
    localparam logic [3:0] SGCC_ADDR_STATUS  = 4'h1;
    localparam logic [3:0] SGCC_ADDR_IRQ_ST  = 4'h2;
    localparam logic [3:0] SGCC_ADDR_IRQ_MSK = 4'h3;
    localparam logic [3:0] SGCC_ADDR_CTRL    = 4'h4;
    // command byte fields
    localparam int SGCC_CMD_SEL_BIT = 7;
    localparam int SGCC_CMD_EN_BIT  = 6;
    localparam int SGCC_CMD_LSB     = 0;
    localparam int SGCC_CMD_MSB     = 1;
    // status byte fields
    localparam int SGCC_ST_NULL_BIT = 7;
    localparam int SGCC_ST_SEL_BIT  = 5;
    localparam int SGCC_ST_BASE_BIT = 3;
    localparam int SGCC_ST_CUR_BIT  = 2;
    localparam int SGCC_ST_TERM_BIT = 1;
    localparam int SGCC_ST_ACT_BIT  = 0;
    // interrupt status bits
    localparam int SGCC_EV_START = 0;
    localparam int SGCC_EV_STOP  = 1;
    localparam int SGCC_EV_DONE  = 2;
    localparam int SGCC_EV_W     = 3;
    // reset values
    localparam logic       SGCC_SEL_RST  = 1'b1;
    localparam logic [7:0] SGCC_BYTE_RST = 8'h00;
    // command codes
    typedef enum logic [1:0] {
        SGCC_CMD_NOP   = 2'b00,
        SGCC_CMD_START = 2'b01,
        SGCC_CMD_STOP  = 2'b10,
        SGCC_CMD_RSVD  = 2'b11
    } sgcc_cmd_t;
endpackage

/* hdl/sgcc_sync.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: input is asynchronous to ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module sgcc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    // next values
    always_comb begin
        nxt_meta = d;
        nxt_q    = meta_ff;
    end

    // two stages, metastability settles in the first
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= nxt_meta;
            q_ff    <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule
